/* hw/lcd_glyph_device.sv */
// Device end: write decoder, glyph, symbol, icon, drive and lamp registers.
// Assumes the host keeps bus-cycle timing and never writes the test slot.
//
// How it works
// RQ1 - Four user glyphs, 160 bits stored.
// RQ2 - Glyph code times eight gives row address.
// RQ3 - Low five bits are pixels, top ignored.
// RQ4 - Eighth row inverted under underline cursor.
// RQ5 - 120-bit symbol store, one bit each.
// RQ6 - One blink bit per five-dot group.
// RQ7 - Icon show and blink at 20H-23H.
// RQ8 - Five icon bits per byte, blink 1-2 Hz; two-line mode blinks at about 2.26 Hz.
// RQ9 - Five-bit drive level at 28H.
// RQ10 - Host never writes test slot 29H.
// RQ11 - Lamp enables and timer selects at 2AH.
// RQ12 - Lamp float, low, or timed low.
// RQ13 - Reset held 10 us, done within 1 us.
// RQ14 - Frame divides oscillator by 13x26 or 13x18.
// RQ15 - External oscillator 33.8 kHz or tied high.
// RQ16 - No bus access in retention sleep.
// RQ17 - Address counter increments after each data write.
// RQ18 - Codes 00H-03H from RAM or ROM.
// RQ19 - One blink phase shared by all blinking.
`timescale 1ns/10ps
`include "lcd_glyph_map.svh"
module lcd_glyph_device #(
  parameter int          EXT_CLOCK   = 0,                  // 1 uses the oscillator pin.
  parameter logic [12:0] OSC_DIV     = 13'(`OSC_DIV_CYC),  // clk cycles per oscillator tick.
  parameter logic [19:0] LAMP_TICKS  = 20'(`LAMP_HOLD_TICKS), // Timed lamp length in ticks.
  parameter logic [5:0]  BLINK_HALF  = 6'(`BLINK_HALF_FRAMES) // Frames per blink half.
) (
  input  wire logic         clk,
  input  wire logic         srst,
  lcd_bus_if.device         bus,
  input  wire logic [7:0]   fetch_code,     // Character code being drawn.
  input  wire logic [2:0]   fetch_row,      // Row of that character.
  input  wire logic         underline_here, // Underline cursor on this glyph.
  output logic [4:0]        fetch_pixels,   // Glyph row, registered.
  output logic              fetch_from_rom, // Code served by fixed ROM.
  output logic [119:0]      symbol_lit,     // Symbols lit, blink applied.
  output logic [9:0]        icon_lit,       // Static icons lit, blink applied.
  output logic [4:0]        drive_level,    // Selected drive level.
  output logic              display_on,     // Display on flag.
  output logic              two_line_mode,  // 1 = two-line, 1/18 duty.
  output logic              frame_tick,     // One pulse per frame.
  output logic              blink_phase     // Shared blink phase.
);
  import lcd_glyph_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  // Bits of the synchronised pin bundle above the data byte.
  localparam int PIN_WR  = 8;
  localparam int PIN_CS  = 9;
  localparam int PIN_A0  = 10;
  localparam int PIN_CLR = 11;
  localparam int PIN_EXT = 12;

  dev_state_type s_q;           // Registered state.
  dev_state_type s_d;           // Next state.
  logic          wr_evt;        // A write cycle ended this cycle.
  logic [7:0]    wd;            // Written byte.
  logic [6:0]    sym_idx;       // Symbol group from address.
  logic          osc_tick;      // One oscillator period passed.
  logic [8:0]    frame_last;    // Last tick count of a frame.
  logic [4:0]    row_mask;      // Inversion for the underline row.
  logic          lamp_hold;     // Timed lamp window open.

  // ==========================================================
  // Next state
  // ==========================================================
  // All storage moves through one copy so each field has one driver.
  always_comb begin
    s_d      = s_q;
    wd       = s_q.in_s[7:0];
    sym_idx  = s_q.addr - `ADDR_SYMBOL_BASE;
    // Every pin goes through two flops before any decoding reads it.
    s_d.in_m = {bus.ext_clock, bus.chip_clear_in_n, bus.command_data_select,
                bus.chip_select_low, bus.write_strobe_low, bus.data};
    s_d.in_s = s_q.in_m;
    s_d.wr_p = s_q.in_s[PIN_WR];
    s_d.cs_p = s_q.in_s[PIN_CS];
    s_d.ext_p = s_q.in_s[PIN_EXT];
    // Select is taken a cycle early, so one rising with the strobe still counts.
    wr_evt   = s_q.in_s[PIN_WR] & ~s_q.wr_p & ~s_q.cs_p;

    // RQ15 oscillator source choice
    if (EXT_CLOCK != 0) begin
      osc_tick = s_q.osc_on & s_q.in_s[PIN_EXT] & ~s_q.ext_p;
    end else begin
      osc_tick = s_q.osc_on & (s_q.osc_cnt == OSC_DIV - 13'h0001);
    end
    if (!s_q.osc_on || osc_tick) begin
      s_d.osc_cnt = 13'h0000;
    end else begin
      s_d.osc_cnt = s_q.osc_cnt + 13'h0001;
    end

    // RQ14 frame divider select
    frame_last     = s_q.setup[3] ? 9'(`FRAME_DIV_2LINE - 1) : 9'(`FRAME_DIV_3LINE - 1);
    s_d.frame_tick = 1'b0;
    if (osc_tick) begin
      if (s_q.frame_cnt >= frame_last) begin
        s_d.frame_cnt  = 9'h000;
        s_d.frame_tick = 1'b1;
      end else begin
        s_d.frame_cnt = s_q.frame_cnt + 9'h001;
      end
    end
    // RQ19 shared blink phase
    if (s_q.frame_tick) begin
      if (s_q.blink_cnt >= BLINK_HALF - 6'h01) begin
        s_d.blink_cnt = 6'h00;
        s_d.blink_ph  = ~s_q.blink_ph;
      end else begin
        s_d.blink_cnt = s_q.blink_cnt + 6'h01;
      end
    end

    // The timed lamp counts oscillator ticks, so it stops with the oscillator.
    if (osc_tick && s_q.hold_cnt != 20'h00000) begin
      s_d.hold_cnt = s_q.hold_cnt - 20'h00001;
    end

    if (wr_evt) begin
      if (s_q.in_s[PIN_A0]) begin
        // RQ17 address auto increment
        s_d.addr = s_q.addr + 7'h01;
        // RQ1 RQ2 RQ3 glyph row store
        if (s_q.addr <= `ADDR_GLYPH_LAST) begin
          s_d.glyph[s_q.addr[4:0]] = wd[4:0];
        end
        // RQ5 RQ6 symbol and blink store
        if (s_q.addr >= `ADDR_SYMBOL_BASE && s_q.addr <= `ADDR_SYMBOL_LAST) begin
          s_d.sym[sym_idx[4:0]]       = wd[4:0];
          s_d.sym_blink[sym_idx[4:0]] = wd[`SYM_BLINK_BIT];
        end
        // RQ7 RQ8 RQ9 RQ11 fixed-address registers
        case (s_q.addr)
          `ADDR_ICON_SHOW_A: s_d.icon_show[4:0]  = wd[4:0];
          `ADDR_ICON_BLNK_A: s_d.icon_blink[4:0] = wd[4:0];
          `ADDR_ICON_SHOW_F: s_d.icon_show[9:5]  = wd[4:0];
          `ADDR_ICON_BLNK_F: s_d.icon_blink[9:5] = wd[4:0];
          `ADDR_DRIVE_LEVEL: s_d.level           = wd[4:0];
          `ADDR_LAMP:        s_d.lamp            = wd[3:0];
          // The test slot and display text addresses store nothing here.
          default: ;
        endcase
      end else if (wd[`CMD_ADDR_BIT]) begin
        s_d.addr = wd[6:0];
      end else begin
        case (wd[7:4])
          `CMD_HOME: s_d.addr = `ADDR_HOME;
          `CMD_DISPLAY: begin
            s_d.disp = wd[3:0];
            // RQ12 timed lamp start
            if (wd[0]) begin
              s_d.hold_cnt = LAMP_TICKS;
            end
          end
          `CMD_POWER_SAVE: s_d.osc_on = wd[1];
          `CMD_SETUP:      s_d.setup  = wd[3:0];
          // No-op, power and test commands are ignored.
          default: ;
        endcase
      end
    end

    // RQ18 RAM or ROM fetch
    s_d.from_rom = ~(s_q.setup[0] && fetch_code[7:2] == 6'h00);
    // RQ4 underline row inversion
    row_mask = {5{underline_here && fetch_row == `GLYPH_LAST_ROW}};
    s_d.pixels = s_d.from_rom ? 5'h00 : (s_q.glyph[{fetch_code[1:0], fetch_row}] ^ row_mask);

    // RQ6 RQ19 symbol blink gating
    for (int g = 0; g < 24; g++) begin
      s_d.sym_lit[g*5 +: 5] = s_q.sym[g] & {5{~(s_q.sym_blink[g] & s_q.blink_ph)}};
    end
    // RQ8 RQ19 icon blink gating
    s_d.icon_lit = s_q.icon_show & ~(s_q.icon_blink & {10{s_q.blink_ph}});

    // RQ13 reset pin clears all but the synchronisers
    if (!s_q.in_s[PIN_CLR]) begin
      s_d       = '0;
      s_d.in_m  = {bus.ext_clock, bus.chip_clear_in_n, bus.command_data_select,
                   bus.chip_select_low, bus.write_strobe_low, bus.data};
      s_d.in_s  = s_q.in_m;
      s_d.wr_p  = 1'b1;
      s_d.cs_p  = 1'b1;
    end
  end

  // Register the whole state; the core reset forces all fields to zero.
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // RQ12 lamp pin drive
  assign lamp_hold        = s_q.hold_cnt != 20'h00000;
  assign bus.lamp_out_one = 1'b0;
  assign bus.lamp_out_two = 1'b0;
  assign bus.lamp_oe_one  = s_q.lamp[`LAMP_EN_ONE] | (s_q.lamp[`LAMP_TIM_ONE] & lamp_hold);
  assign bus.lamp_oe_two  = s_q.lamp[`LAMP_EN_TWO] | (s_q.lamp[`LAMP_TIM_TWO] & lamp_hold);
  assign fetch_pixels     = s_q.pixels;
  assign fetch_from_rom   = s_q.from_rom;
  assign symbol_lit       = s_q.sym_lit;
  assign icon_lit         = s_q.icon_lit;
  assign drive_level      = s_q.level;
  assign display_on       = s_q.disp[0];
  assign two_line_mode    = s_q.setup[3];
  assign frame_tick       = s_q.frame_tick;
  assign blink_phase      = s_q.blink_ph;
endmodule

/* hw/lcd_glyph_map.svh */
// Constants for the glyph, icon and lamp register bank and its write bus.
// Assumes a 250 MHz core clock on both ends of the link.
`ifndef LCD_GLYPH_MAP_SVH
`define LCD_GLYPH_MAP_SVH

// ==========================================================
// Clock and timing
// ==========================================================
`define CLK_PERIOD_NS   4
`define CYC_MIN(ns)     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_SETUP_NS      60
`define T_LOW_NS        150
`define T_HOLD_NS       50
`define T_CYCLE_NS      1850
`define T_CLEAR_US      10
`define T_RECOVER_NS    1000
`define CLK_FREQ_HZ     250000000
`define OSC_FREQ_HZ     33800
`define OSC_DIV_CYC     (`CLK_FREQ_HZ / `OSC_FREQ_HZ)
`define LAMP_HOLD_S     15
`define LAMP_HOLD_TICKS (`LAMP_HOLD_S * `OSC_FREQ_HZ)
`define FRAME_DIV_3LINE (13 * 26)
`define FRAME_DIV_2LINE (13 * 18)
`define BLINK_HALF_FRAMES 32

// ==========================================================
// Register offsets
// ==========================================================
`define ADDR_GLYPH_LAST  7'h1F
`define ADDR_ICON_SHOW_A 7'h20
`define ADDR_ICON_BLNK_A 7'h21
`define ADDR_ICON_SHOW_F 7'h22
`define ADDR_ICON_BLNK_F 7'h23
`define ADDR_DRIVE_LEVEL 7'h28
`define ADDR_FACTORY     7'h29
`define ADDR_LAMP        7'h2A
`define ADDR_HOME        7'h30
`define ADDR_SYMBOL_BASE 7'h60
`define ADDR_SYMBOL_LAST 7'h77

// ==========================================================
// Field positions and command codes
// ==========================================================
`define LAMP_EN_ONE    0
`define LAMP_EN_TWO    1
`define LAMP_TIM_ONE   2
`define LAMP_TIM_TWO   3
`define SYM_BLINK_BIT  5
`define CMD_HOME       4'h1
`define CMD_DISPLAY    4'h3
`define CMD_POWER_SAVE 4'h4
`define CMD_SETUP      4'h6
`define CMD_ADDR_BIT   7
`define GLYPH_LAST_ROW 3'h7

`endif

/* hw/lcd_glyph_pkg.sv */
// Types shared by both ends of the glyph register bank link.
// Assumes the constants header is included by the modules that need it.
package lcd_glyph_pkg;

  // Host bus-cycle sequencer states.
  typedef enum logic [2:0] {
    H_CLEAR, H_RECOVER, H_IDLE, H_SETUP, H_LOW, H_HOLD, H_GAP
  } host_state_type;

  // Device state: synchronisers, registers and timebase.
  typedef struct packed {
    logic [12:0]      in_m;       // First synchroniser stage of the pins.
    logic [12:0]      in_s;       // Second synchroniser stage of the pins.
    logic             wr_p;       // Previous synchronised write strobe.
    logic             cs_p;       // Previous synchronised select.
    logic             ext_p;      // Previous synchronised oscillator pin.
    logic [6:0]       addr;       // Write address counter.
    logic [31:0][4:0] glyph;      // User glyph rows.
    logic [23:0][4:0] sym;        // Symbol dots, five per group.
    logic [23:0]      sym_blink;  // Blink enable per symbol group.
    logic [9:0]       icon_show;  // Static icon display enables.
    logic [9:0]       icon_blink; // Static icon blink enables.
    logic [4:0]       level;      // Drive level.
    logic [3:0]       lamp;       // Lamp control bits.
    logic [3:0]       disp;       // Cursor, blink, double, display on.
    logic [3:0]       setup;      // Line mode, flips, glyph select.
    logic             osc_on;     // Oscillator running.
    logic [12:0]      osc_cnt;    // Internal oscillator prescaler.
    logic [8:0]       frame_cnt;  // Oscillator ticks within a frame.
    logic [5:0]       blink_cnt;  // Frames within a blink half period.
    logic             blink_ph;   // Shared blink phase, 1 = dark half.
    logic [19:0]      hold_cnt;   // Timed lamp countdown.
    logic             frame_tick; // One-cycle frame pulse.
    logic [4:0]       pixels;     // Fetched glyph row.
    logic             from_rom;   // Fetch goes to the fixed ROM.
    logic [119:0]     sym_lit;    // Symbols lit this cycle.
    logic [9:0]       icon_lit;   // Icons lit this cycle.
  } dev_state_type;

  // Host state: bus cycle sequencer and oscillator source.
  typedef struct packed {
    host_state_type st;
    logic [11:0]    cnt;
    logic           cs_n;
    logic           wr_n;
    logic           a0;
    logic [7:0]     data;
    logic           clr_n;
    logic [6:0]     addr;
    logic           ext;
    logic [11:0]    ext_cnt;
  } host_state_type_s_type;

endpackage

/* hw/lcd_bus_if.sv */
// Write-only parallel bus, reset pin, oscillator pin and lamp pins.
// Assumes both ends run on the same clk; the lamp wires resolve here.
`timescale 1ns/10ps
interface lcd_bus_if;
  logic       chip_select_low;     // Select, low active.
  logic       write_strobe_low;    // Write strobe, rising edge latches.
  logic       command_data_select; // 0 command, 1 data.
  logic [7:0] data;                // Write data.
  logic       chip_clear_in_n;     // Reset pin, low active.
  logic       ext_clock;           // External oscillator, high when unused.
  logic       lamp_out_one;        // Lamp one driven value.
  logic       lamp_oe_one;         // Lamp one drive enable.
  logic       lamp_out_two;        // Lamp two driven value.
  logic       lamp_oe_two;         // Lamp two drive enable.
  wire        lamp_drive_out_one;  // Resolved lamp one pin.
  wire        lamp_drive_out_two;  // Resolved lamp two pin.

  // An undriven lamp pin rests high through its lamp to the supply.
  assign lamp_drive_out_one = lamp_oe_one ? lamp_out_one : 1'b1;
  assign lamp_drive_out_two = lamp_oe_two ? lamp_out_two : 1'b1;

  modport device (
    input  chip_select_low, write_strobe_low, command_data_select, data,
    input  chip_clear_in_n, ext_clock,
    output lamp_out_one, lamp_oe_one, lamp_out_two, lamp_oe_two
  );
  modport host (
    output chip_select_low, write_strobe_low, command_data_select, data,
    output chip_clear_in_n, ext_clock,
    input  lamp_drive_out_one, lamp_drive_out_two
  );
endinterface

/* hw/lcd_glyph_host.sv */
// Host end: turns queued command and data bytes into timed bus cycles.
// Assumes one byte is offered at a time on the same clk as the device.
`timescale 1ns/10ps
`include "lcd_glyph_map.svh"
module lcd_glyph_host #(
  parameter int          EXT_CLOCK = 0,                          // 1 drives the oscillator pin.
  parameter logic [11:0] CLEAR_CYC = 12'(`T_CLEAR_US * 1000 / `CLK_PERIOD_NS) // Reset hold.
) (
  input  wire logic       clk,
  input  wire logic       srst,
  lcd_bus_if.host         bus,
  input  wire logic       cmd_valid,      // Byte offered.
  input  wire logic       cmd_is_data,    // 1 data write, 0 command.
  input  wire logic [7:0] cmd_byte,       // Byte to send.
  output logic            cmd_ready,      // Byte taken when valid too.
  input  wire logic       clear_req,      // Pulse to reset the device.
  input  wire logic       retention_hold, // Low supply, bus frozen.
  output logic            lamp_one_lit,   // Lamp one pin sinking.
  output logic            lamp_two_lit    // Lamp two pin sinking.
);
  import lcd_glyph_pkg::*;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam logic [11:0] SET_C = 12'(`CYC_MIN(`T_SETUP_NS));
  localparam logic [11:0] LOW_C = 12'(`CYC_MIN(`T_LOW_NS));
  localparam logic [11:0] HLD_C = 12'(`CYC_MIN(`T_HOLD_NS));
  localparam logic [11:0] GAP_C = 12'(`CYC_MIN(`T_CYCLE_NS)) - SET_C - LOW_C - HLD_C;
  localparam logic [11:0] REC_C = 12'(`CYC_MIN(`T_RECOVER_NS));
  localparam logic [11:0] OSC_HALF = 12'(`OSC_DIV_CYC / 2);

  host_state_type_s_type h_q; // Registered state.
  host_state_type_s_type h_d; // Next state.
  logic                  done; // Current phase count reached.

  // RQ16 no access in retention
  assign cmd_ready = (h_q.st == H_IDLE) & ~retention_hold;

  // ==========================================================
  // Sequencer
  // ==========================================================
  // Each bus phase waits out its own minimum time before the next begins.
  always_comb begin
    h_d  = h_q;
    done = 1'b0;
    // RQ15 oscillator pin source
    if (EXT_CLOCK != 0) begin
      if (h_q.ext_cnt >= OSC_HALF - 12'h001) begin
        h_d.ext_cnt = 12'h000;
        h_d.ext     = ~h_q.ext;
      end else begin
        h_d.ext_cnt = h_q.ext_cnt + 12'h001;
      end
    end else begin
      h_d.ext = 1'b1;
    end
    h_d.cnt = h_q.cnt + 12'h001;
    case (h_q.st)
      H_CLEAR:   done = h_q.cnt >= CLEAR_CYC - 12'h001;
      H_RECOVER: done = h_q.cnt >= REC_C - 12'h001;
      H_SETUP:   done = h_q.cnt >= SET_C - 12'h001;
      H_LOW:     done = h_q.cnt >= LOW_C - 12'h001;
      H_HOLD:    done = h_q.cnt >= HLD_C - 12'h001;
      H_GAP:     done = h_q.cnt >= GAP_C - 12'h001;
      default:   done = 1'b0;
    endcase
    if (done) begin
      h_d.cnt = 12'h000;
    end
    case (h_q.st)
      // RQ13 reset pulse hold
      H_CLEAR: if (done) begin
        h_d.clr_n = 1'b1;
        h_d.st    = H_RECOVER;
      end
      // RQ13 recovery before first cycle
      H_RECOVER: if (done) h_d.st = H_IDLE;
      H_IDLE: begin
        h_d.cnt = 12'h000;
        if (cmd_valid && cmd_ready) begin
          h_d.st   = H_SETUP;
          h_d.cs_n = 1'b0;
          h_d.a0   = cmd_is_data;
          h_d.data = cmd_byte;
          if (cmd_is_data) begin
            h_d.addr = h_q.addr + 7'h01;
            // RQ10 test slot skipped
            if (h_q.addr == `ADDR_FACTORY) begin
              h_d.a0   = 1'b0;
              h_d.data = {1'b1, `ADDR_LAMP};
              h_d.addr = `ADDR_LAMP;
            end
          end else if (cmd_byte[`CMD_ADDR_BIT]) begin
            h_d.addr = cmd_byte[6:0];
          end else if (cmd_byte[7:4] == `CMD_HOME) begin
            h_d.addr = `ADDR_HOME;
          end
        end
      end
      H_SETUP: if (done) begin
        h_d.wr_n = 1'b0;
        h_d.st   = H_LOW;
      end
      H_LOW: if (done) begin
        h_d.wr_n = 1'b1;
        h_d.st   = H_HOLD;
      end
      H_HOLD: if (done) begin
        h_d.cs_n = 1'b1;
        h_d.st   = H_GAP;
      end
      H_GAP: if (done) h_d.st = H_IDLE;
      default: h_d.st = H_IDLE;
    endcase
    // A clear request aborts any cycle; the device discards it with its reset.
    if (clear_req) begin
      h_d.st    = H_CLEAR;
      h_d.cnt   = 12'h000;
      h_d.clr_n = 1'b0;
      h_d.addr  = 7'h00;
      h_d.cs_n  = 1'b1;
      h_d.wr_n  = 1'b1;
    end
  end

  // Core reset starts in the clear state so the device is reset too.
  always_ff @(posedge clk) begin
    if (srst) begin
      h_q       <= '0;
      h_q.st    <= H_CLEAR;
      h_q.cs_n  <= 1'b1;
      h_q.wr_n  <= 1'b1;
      h_q.ext   <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.chip_select_low     = h_q.cs_n;
  assign bus.write_strobe_low    = h_q.wr_n;
  assign bus.command_data_select = h_q.a0;
  assign bus.data                = h_q.data;
  assign bus.chip_clear_in_n     = h_q.clr_n;
  assign bus.ext_clock           = h_q.ext;
  assign lamp_one_lit            = ~bus.lamp_drive_out_one;
  assign lamp_two_lit            = ~bus.lamp_drive_out_two;
endmodule

/* tb/lcd_bus_chk.sv */
// Checker for the glyph bank bus, reset, oscillator and lamp pins.
// Assumes it sits beside the interface and shares its clk and srst.
`timescale 1ns/10ps
module lcd_bus_chk #(
  parameter int CLEAR_CYC = 8 // Reset pin low time in clk cycles.
) (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       chip_select_low,
  input wire logic       write_strobe_low,
  input wire logic       command_data_select,
  input wire logic [7:0] data,
  input wire logic       chip_clear_in_n,
  input wire logic       ext_clock,
  input wire logic       lamp_out_one,
  input wire logic       lamp_oe_one,
  input wire logic       lamp_out_two,
  input wire logic       lamp_oe_two
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [9:0] low_q; // Length of the current strobe low run.
  logic [9:0] gap_q; // Cycles since the last strobe fall, saturating.
  // ==========================================================
  // Helper counters
  // ==========================================================
  // The gap starts saturated, so the first write after reset is legal.
  always_ff @(posedge clk) begin
    if (srst) begin
      low_q <= 10'h000;
      gap_q <= 10'h3FF;
    end else begin
      low_q <= write_strobe_low ? 10'h000 : low_q + 10'h001;
      gap_q <= $fell(write_strobe_low) ? 10'h001 : gap_q + {9'h000, gap_q != 10'h3FF};
    end
  end
  // ==========================================================
  // Assertions
  // ==========================================================
  strobe_in_select_a: assert property (!write_strobe_low |-> !chip_select_low)
    else $error("write strobe low outside select");
  data_held_a: assert property (!write_strobe_low |-> $stable(data) && $stable(command_data_select))
    else $error("data moved under strobe");
  strobe_low_width_a: assert property ($rose(write_strobe_low) |-> low_q >= 10'd38)
    else $error("strobe low too short");
  write_cycle_time_a: assert property ($fell(write_strobe_low) |-> gap_q >= 10'd463)
    else $error("write cycle too short");
  select_hold_a: assert property ($rose(write_strobe_low) |-> (!chip_select_low && $stable(data))[*8] ##5 !chip_select_low)
    else $error("select or data hold too short");
  lamp_one_sink_a: assert property (lamp_oe_one |-> !lamp_out_one)
    else $error("lamp one driven high");
  lamp_two_sink_a: assert property (lamp_oe_two |-> !lamp_out_two)
    else $error("lamp two driven high");
  clear_width_a: assert property ($rose(chip_clear_in_n) |-> !$past(chip_clear_in_n, CLEAR_CYC))
    else $error("reset pulse too short");
  ext_idle_high_a: assert property (ext_clock)
    else $error("unused oscillator pin not high");
  cover property ($rose(write_strobe_low) && command_data_select);
  cover property ($rose(lamp_oe_two));
  cover property ($rose(chip_clear_in_n));
endmodule

/* tb/lcd_glyph_icon_led_registers_bench.sv */
// Bench joining host and device ends and checking the register bank.
// Assumes the package, header and interface are compiled first.
`timescale 1ns/10ps
module lcd_glyph_icon_led_registers_bench;
  import lcd_glyph_pkg::*;
  localparam int OSC = 4;  // Shortened oscillator divide.
  localparam int LAMP = 20; // Shortened timed lamp length in ticks.
  logic clk, srst, cmd_valid, cmd_is_data, clear_req, retention_hold, cmd_ready;
  logic lamp_one_lit, lamp_two_lit, underline_here, fetch_from_rom, display_on;
  logic two_line_mode, frame_tick, blink_phase;
  logic [7:0] cmd_byte, fetch_code;
  logic [2:0] fetch_row;
  logic [4:0] fetch_pixels, drive_level;
  logic [119:0] symbol_lit;
  logic [9:0] icon_lit;
  int num_errors, n_compared, n;
  lcd_bus_if i_bus();
  lcd_glyph_host #(.CLEAR_CYC(12'h008)) i_lcd_glyph_host (.clk, .srst, .bus(i_bus),
    .cmd_valid, .cmd_is_data, .cmd_byte, .cmd_ready, .clear_req, .retention_hold,
    .lamp_one_lit, .lamp_two_lit);
  lcd_glyph_device #(.OSC_DIV(13'h0004), .LAMP_TICKS(20'h00014), .BLINK_HALF(6'h02))
    i_lcd_glyph_device (.clk, .srst, .bus(i_bus), .fetch_code, .fetch_row, .underline_here,
    .fetch_pixels, .fetch_from_rom, .symbol_lit, .icon_lit, .drive_level, .display_on,
    .two_line_mode, .frame_tick, .blink_phase);
  lcd_bus_chk #(.CLEAR_CYC(8)) i_lcd_bus_chk (.clk, .srst,
    .chip_select_low(i_bus.chip_select_low), .write_strobe_low(i_bus.write_strobe_low),
    .command_data_select(i_bus.command_data_select), .data(i_bus.data),
    .chip_clear_in_n(i_bus.chip_clear_in_n), .ext_clock(i_bus.ext_clock),
    .lamp_out_one(i_bus.lamp_out_one), .lamp_oe_one(i_bus.lamp_oe_one),
    .lamp_out_two(i_bus.lamp_out_two), .lamp_oe_two(i_bus.lamp_oe_two));
  // ==========================================================
  // Clock and shared tasks
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check_val(input logic [119:0] got, input logic [119:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits for the host to finish its bus cycle, bounded against a hang.
  task automatic idle();
    for (n = 0; cmd_ready !== 1'b1 && n < 1000; n++) @(negedge clk);
    if (n >= 1000) num_errors++;
  endtask
  task automatic send(input logic d, input logic [7:0] b);
    idle();
    cmd_valid = 1'b1;
    cmd_is_data = d;
    cmd_byte = b;
    @(negedge clk);
    cmd_valid = 1'b0;
  endtask
  task automatic fetch(input logic [7:0] c, input logic [2:0] r, input logic u, input logic [5:0] e);
    fetch_code = c;
    fetch_row = r;
    underline_here = u;
    repeat (2) @(negedge clk);
    check_val({fetch_from_rom, fetch_pixels}, e);
  endtask
  // Measures one whole frame, from the first pulse seen to the next.
  task automatic frame_len(input int exp);
    for (n = 0; frame_tick !== 1'b1 && n < 3000; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; frame_tick !== 1'b1 && n < 3000; n++) @(negedge clk);
    check_val(n, exp);
  endtask
  task automatic wait_blink(input logic v);
    for (n = 0; blink_phase !== v && n < 4000; n++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The tests need about 20000 cycles; the watchdog allows two and a half times that.
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    {cmd_valid, cmd_is_data, cmd_byte, clear_req, retention_hold} = '0;
    {fetch_code, fetch_row, underline_here, num_errors, n_compared} = '0;
    srst = 1'b1;
    repeat (20) @(negedge clk);
    srst = 1'b0;
    idle();
    retention_hold = 1'b1;
    @(negedge clk);
    check_val(cmd_ready, 1'b0);
    retention_hold = 1'b0;
    check_val(i_bus.lamp_oe_one, 1'b0);
    send(0, 8'h88); send(1, 8'hEA); send(1, 8'hF3); send(0, 8'h8F); send(1, 8'h05); send(0, 8'h61);
    idle();
    fetch(8'h01, 3'h0, 1'b0, 6'h0A);
    fetch(8'h01, 3'h1, 1'b0, 6'h13);
    fetch(8'h01, 3'h7, 1'b0, 6'h05);
    fetch(8'h01, 3'h7, 1'b1, 6'h1A);
    fetch(8'h03, 3'h0, 1'b0, 6'h00);
    fetch(8'h04, 3'h0, 1'b0, 6'h20);
    send(0, 8'hA0); send(1, 8'hE7); send(1, 8'h11); send(1, 8'h15); send(1, 8'h00);
    send(0, 8'hA8); send(1, 8'hFF); send(1, 8'h01);
    idle();
    check_val(drive_level, 5'h1F);
    check_val(i_bus.lamp_oe_one, 1'b0);
    send(1, 8'h01);
    idle();
    check_val(lamp_one_lit, 1'b1);
    send(0, 8'hAA); send(1, 8'h08); send(0, 8'hE0); send(1, 8'h3F); send(1, 8'h1F);
    idle();
    check_val(i_bus.lamp_oe_one, 1'b0);
    check_val(icon_lit, 10'h2A7);
    send(0, 8'h42);
    send(0, 8'h31);
    for (n = 0; lamp_two_lit !== 1'b1 && n < 200; n++) @(negedge clk);
    for (n = 0; lamp_two_lit === 1'b1 && n < 300; n++) @(negedge clk);
    check_val(n >= LAMP * OSC - 8 && n <= LAMP * OSC + 8, 1'b1);
    check_val(display_on, 1'b1);
    wait_blink(1'b1);
    check_val(icon_lit, 10'h2A6);
    check_val(symbol_lit[9:0], 10'h3E0);
    wait_blink(1'b0);
    check_val(icon_lit, 10'h2A7);
    check_val(symbol_lit[9:0], 10'h3FF);
    frame_len(13 * 26 * OSC);
    send(0, 8'h69);
    idle();
    check_val(two_line_mode, 1'b1);
    frame_len(13 * 18 * OSC);
    clear_req = 1'b1;
    @(negedge clk);
    clear_req = 1'b0;
    idle();
    check_val({two_line_mode, drive_level}, 6'h00);
    wrap_up();
  end
endmodule
